//--- power_mode_pkg.sv
// Function
// - three power modes: normal, standby, low-power
// - standby only in serial mode, field 01
// - standby disables high-speed data and clock channels
// - standby keeps serial control and repeater running
// - low-power from pin low or, in serial mode only, register request
// - low-power disables receivers, terminations, repeaters and link outputs
// - low-power hot-plug outputs follow source power
// - no link clock: data terminations off, outputs off
// - valid link clock in normal mode: terminations on, outputs driven
// - separate source-power detection on four ports
// - indicator high when any source power high
// - serial mode shows source power in 0x01
// - outside low-power, selected hot-plug follows sink, others follow power
package power_mode_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_ADDR    = 8'h01;
    localparam logic [7:0] CONTROL_ADDR   = 8'h02;
    localparam logic [7:0] INT_STAT_ADDR  = 8'h03;
    localparam logic [7:0] INT_MASK_ADDR  = 8'h04;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POWER_FIELD_HI  = 7;
    localparam int POWER_FIELD_LO  = 6;
    localparam int SELECT_FIELD_HI = 1;
    localparam int SELECT_FIELD_LO = 0;
    localparam int STATUS_SEL_LO   = 4;
    localparam int STATUS_CLK_BIT  = 6;

    localparam logic [1:0] POWER_STANDBY = 2'h1;
    localparam int         LOWPOWER_BIT  = 7;

    // interrupt status bits
    localparam int EV_SENSE  = 0;
    localparam int EV_SELECT = 1;
    localparam int EV_CLOCK  = 2;
    localparam int EV_MODE   = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_RESET  = 8'h00;
    localparam logic [3:0] INT_MASK_RESET = 4'h0;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_STANDBY, MODE_LOWPOWER} mode_t;

endpackage

//--- sync_two_flop.sv
module sync_two_flop
    import power_mode_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,     // system clock
    input  wire logic             resetN,   // async reset, active low
    input  wire logic [WIDTH-1:0] asyncIn,  // level from another domain
    output logic      [WIDTH-1:0] syncOut   // synchronised level
);

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_t;

    sync_t state;
    sync_t next_state;

    always_comb begin
        next_state.first  = asyncIn;
        next_state.second = state.first;
    end

    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign syncOut = state.second;

endmodule

//--- power_mode_hotplug_control.sv
module power_mode_hotplug_control
    import power_mode_pkg::*;
#(
    parameter int PORTS = 4
) (
    input  wire logic             mclk,                   // 200 MHz system clock
    input  wire logic             rst_n,                  // async reset, active low
    input  wire logic             low_power_pin_n,        // low-power request pin
    input  wire logic             sink_hotplug_in,        // hot-plug from sink
    input  wire logic [PORTS-1:0] source_power_sense,     // bit 0 is port 1
    input  wire logic [1:0]       port_select_pins,       // pin-strap port select
    input  wire logic             control_mode_select,    // 1 serial, 0 pin-strap
    input  wire logic             linkClockValid,         // clock detect of selected port
    input  wire logic [7:0]       regAddr,                // register address
    input  wire logic [7:0]       regWriteData,           // register write data
    input  wire logic             regWrite,               // write strobe
    input  wire logic             regRead,                // read strobe
    output logic      [7:0]       regReadData,            // read data, cycle after strobe
    output logic      [PORTS-1:0] port_hotplug_out,       // hot-plug to each source
    output logic                  source_power_indicator, // any source powered
    output logic      [PORTS-1:0] receiverEnable,         // input receivers on
    output logic      [PORTS-1:0] clockTermEnable,        // clock-line terminations
    output logic      [PORTS-1:0] dataTermEnable,         // data-line terminations
    output logic      [PORTS-1:0] ddcRepeaterEnable,      // repeater per port
    output logic                  linkOutputEnable,       // link outputs driven
    output logic                  irq                     // level interrupt
);

    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic       resetN;
    logic       lowPowerSync_n;
    logic       lowPowerPinReq;
    logic       sinkHotplugSync;
    logic [PORTS-1:0] senseSync;
    logic [1:0] selectPinSync;
    logic       serialMode;
    logic       clockValidSync;

    sync_two_flop #(.WIDTH(1)) resetRelease (
        .mclk    (mclk),
        .resetN  (rst_n),
        .asyncIn (1'b1),
        .syncOut (resetN)
    );

    sync_two_flop #(.WIDTH(PORTS + 6)) pinSync (
        .mclk    (mclk),
        .resetN  (resetN),
        .asyncIn ({~low_power_pin_n, sink_hotplug_in, source_power_sense,
                   port_select_pins, control_mode_select, linkClockValid}),
        .syncOut ({lowPowerPinReq, sinkHotplugSync, senseSync,
                   selectPinSync, serialMode, clockValidSync})
    );

    // carried inverted so the flops reset to the idle pin level
    assign lowPowerSync_n = ~lowPowerPinReq;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mode_t            mode;
        logic [7:0]       control;
        logic [3:0]       intStatus;
        logic [3:0]       intMask;
        logic [7:0]       readData;
        logic [PORTS-1:0] lastSense;
        logic [1:0]       lastSelect;
        logic             lastClock;
        logic [PORTS-1:0] hotplug;
        logic             indicator;
        logic [PORTS-1:0] rxEnable;
        logic [PORTS-1:0] clkTerm;
        logic [PORTS-1:0] dataTerm;
        logic [PORTS-1:0] ddcEnable;
        logic             linkOut;
        logic             irq;
    } ctrl_state_t;

    ctrl_state_t state;
    ctrl_state_t next_state;

    function automatic logic [PORTS-1:0] portOneHot(input logic [1:0] sel);
        logic [PORTS-1:0] hot;
        hot = '0;
        hot[sel] = 1'b1;
        return hot;
    endfunction

    // ------------------------------------------------------------
    // mode and port decisions
    // ------------------------------------------------------------
    logic       lowPowerReq;
    logic       standbyReq;
    mode_t      modeNow;
    logic [1:0] selectNow;
    logic [PORTS-1:0] selectHot;
    logic [PORTS-1:0] hotplugNow;
    logic [3:0] events;
    logic [3:0] clearBits;

    always_comb begin
        lowPowerReq = !lowPowerSync_n
                      || (serialMode && state.control[LOWPOWER_BIT]);
        standbyReq  = serialMode && (state.control[POWER_FIELD_HI:POWER_FIELD_LO]
                                     == POWER_STANDBY);
        if (lowPowerReq) begin
            modeNow = MODE_LOWPOWER;
        end else if (standbyReq) begin
            modeNow = MODE_STANDBY;
        end else begin
            modeNow = MODE_NORMAL;
        end
        selectNow = serialMode ? state.control[SELECT_FIELD_HI:SELECT_FIELD_LO]
                               : selectPinSync;
        selectHot = portOneHot(selectNow);
    end

    generate
        for (genvar p = 0; p < PORTS; p++) begin : gHotplug
            always_comb begin
                if (modeNow == MODE_LOWPOWER) begin
                    hotplugNow[p] = senseSync[p];
                end else if (selectHot[p]) begin
                    hotplugNow[p] = sinkHotplugSync;
                end else begin
                    hotplugNow[p] = senseSync[p];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.mode       = modeNow;
        next_state.lastSense  = senseSync;
        next_state.lastSelect = selectNow;
        next_state.lastClock  = clockValidSync;
        next_state.hotplug    = hotplugNow;
        next_state.indicator  = |senseSync;

        // power gating of the link path
        next_state.rxEnable  = (modeNow == MODE_NORMAL) ? selectHot : '0;
        next_state.clkTerm   = (modeNow == MODE_NORMAL) ? selectHot : '0;
        next_state.dataTerm  = (modeNow == MODE_NORMAL && clockValidSync)
                               ? selectHot : '0;
        next_state.linkOut   = (modeNow == MODE_NORMAL) && clockValidSync;
        next_state.ddcEnable = (modeNow != MODE_LOWPOWER)
                               ? selectHot : '0;

        // events
        events            = '0;
        events[EV_SENSE]  = senseSync != state.lastSense;
        events[EV_SELECT] = selectNow != state.lastSelect;
        events[EV_CLOCK]  = clockValidSync != state.lastClock;
        events[EV_MODE]   = modeNow != state.mode;

        // register writes
        clearBits = '0;
        if (regWrite) begin
            unique case (regAddr)
                CONTROL_ADDR:  next_state.control = regWriteData;
                INT_STAT_ADDR: clearBits = regWriteData[3:0];
                INT_MASK_ADDR: next_state.intMask = regWriteData[3:0];
                default: ;
            endcase
        end
        // a new event beats a clear in the same cycle
        next_state.intStatus = (state.intStatus & ~clearBits) | events;
        next_state.irq       = |(next_state.intStatus & next_state.intMask);

        // register reads
        next_state.readData = '0;
        if (regRead) begin
            unique case (regAddr)
                STATUS_ADDR: begin
                    if (serialMode) begin
                        next_state.readData = {1'b0, clockValidSync, selectNow,
                                               senseSync};
                    end
                end
                CONTROL_ADDR:  next_state.readData = state.control;
                INT_STAT_ADDR: next_state.readData = {4'h0, state.intStatus};
                INT_MASK_ADDR: next_state.readData = {4'h0, state.intMask};
                default:       next_state.readData = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            state            <= '0;
            state.mode       <= MODE_NORMAL;
            state.control    <= CONTROL_RESET;
            state.intMask    <= INT_MASK_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign regReadData            = state.readData;
    assign port_hotplug_out       = state.hotplug;
    assign source_power_indicator = state.indicator;
    assign receiverEnable         = state.rxEnable;
    assign clockTermEnable        = state.clkTerm;
    assign dataTermEnable         = state.dataTerm;
    assign ddcRepeaterEnable      = state.ddcEnable;
    assign linkOutputEnable       = state.linkOut;
    assign irq                    = state.irq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetN);

    mode_three_a: assert property (state.mode inside {MODE_NORMAL, MODE_STANDBY,
                                                      MODE_LOWPOWER})
        else $error("illegal power mode");

    standby_serial_a: assert property (next_state.mode == MODE_STANDBY
                                       |-> serialMode && lowPowerSync_n)
        else $error("standby outside serial control");

    standby_links_a: assert property (state.mode == MODE_STANDBY
                                      |-> receiverEnable == '0 && !linkOutputEnable)
        else $error("link channels live in standby");

    standby_ddc_a: assert property (state.mode == MODE_STANDBY
                                    |-> ddcRepeaterEnable != '0)
        else $error("repeater off in standby");

    pin_lowpower_a: assert property ($fell(lowPowerSync_n) |=> state.mode == MODE_LOWPOWER)
        else $error("low-power pin ignored");

    lowpower_off_a: assert property (state.mode == MODE_LOWPOWER
                                     |-> {receiverEnable, clockTermEnable, dataTermEnable,
                                          ddcRepeaterEnable, linkOutputEnable} == '0)
        else $error("io active in low-power");

    lowpower_hotplug_a: assert property (next_state.mode == MODE_LOWPOWER
                                         |=> port_hotplug_out == $past(senseSync))
        else $error("hot-plug not following power in low-power");

    noclock_gate_a: assert property (!clockValidSync |=> dataTermEnable == '0
                                     && !linkOutputEnable)
        else $error("terminations on without link clock");

    clock_connect_a: assert property (clockValidSync && next_state.mode == MODE_NORMAL
                                      |=> linkOutputEnable
                                          && dataTermEnable == receiverEnable)
        else $error("link not connected with valid clock");

    indicator_any_a: assert property (1'b1 |=> source_power_indicator
                                      == |$past(senseSync))
        else $error("indicator wrong");

    selected_follow_a: assert property (next_state.mode != MODE_LOWPOWER
                                        |=> port_hotplug_out[$past(selectNow)]
                                            == $past(sinkHotplugSync))
        else $error("selected hot-plug not following sink");

    lowpower_wins_a: assert property (lowPowerReq && standbyReq
                                      |=> state.mode == MODE_LOWPOWER)
        else $error("standby beat low-power");

    // ------------------------------------------------------------
    // port gating and register checks
    // ------------------------------------------------------------
    unselected_sense_a: assert property (next_state.mode != MODE_LOWPOWER
        |=> (port_hotplug_out & ~$past(selectHot)) == ($past(senseSync) & ~$past(selectHot)))
        else $error("unselected hot-plug not following power");

    normal_enable_a: assert property (next_state.mode == MODE_NORMAL
        |=> clockTermEnable == $past(selectHot) && receiverEnable == $past(selectHot))
        else $error("receivers off in normal mode");

    normal_ddc_a: assert property (next_state.mode == MODE_NORMAL
        |=> ddcRepeaterEnable == $past(selectHot))
        else $error("repeater off in normal mode");

    clock_port_a: assert property (clockValidSync && next_state.mode == MODE_NORMAL
        |=> dataTermEnable == $past(selectHot))
        else $error("data terminations not on selected port");

    standby_terms_a: assert property (state.mode == MODE_STANDBY
        |-> clockTermEnable == '0 && dataTermEnable == '0)
        else $error("terminations on in standby");

    reg_lowpower_a: assert property (serialMode && state.control[LOWPOWER_BIT]
        |=> state.mode == MODE_LOWPOWER)
        else $error("low-power request ignored");

    normal_return_a: assert property (lowPowerSync_n && !standbyReq
        && !(serialMode && state.control[LOWPOWER_BIT]) |=> state.mode == MODE_NORMAL)
        else $error("normal mode not resumed");

    status_serial_a: assert property (regRead && regAddr == STATUS_ADDR && serialMode
        |=> regReadData[PORTS-1:0] == $past(senseSync)
            && regReadData[STATUS_CLK_BIT] == $past(clockValidSync))
        else $error("status read wrong");

    status_pins_a: assert property (regRead && regAddr == STATUS_ADDR && !serialMode
        |=> regReadData == '0)
        else $error("status visible in pin-strap mode");

    read_once_a: assert property (!regRead |=> regReadData == '0)
        else $error("read data outside its cycle");

    control_write_a: assert property (regWrite && regAddr == CONTROL_ADDR
        |=> state.control == $past(regWriteData))
        else $error("control write lost");

    mask_write_a: assert property (regWrite && regAddr == INT_MASK_ADDR
        |=> state.intMask == $past(regWriteData[3:0]))
        else $error("mask write lost");

    event_sticky_a: assert property (1'b1 |=> (state.intStatus & $past(events))
        == $past(events))
        else $error("event lost");

    status_clear_a: assert property (regWrite && regAddr == INT_STAT_ADDR
        && regWriteData[EV_SENSE] && !events[EV_SENSE] |=> !state.intStatus[EV_SENSE])
        else $error("status bit not cleared");

    irq_level_a: assert property (irq == |(state.intStatus & state.intMask))
        else $error("interrupt level wrong");

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    cover_standby: cover property (state.mode == MODE_NORMAL ##1 state.mode == MODE_STANDBY);
    cover_lowpower: cover property (state.mode == MODE_LOWPOWER);
    cover_clock_up: cover property ($rose(linkOutputEnable));
    cover_irq: cover property ($rose(irq));
    cover_pin_request: cover property ($fell(lowPowerSync_n));

endmodule

//--- far_side_model.sv
module far_side_model (
    input  wire logic       mclk,                // clock
    input  wire logic [1:0] reqPort,             // wanted port
    input  wire logic       reqSink,             // wanted sink level
    input  wire logic [3:0] reqPower,            // wanted power
    input  wire logic       reqClock,            // wanted clock detect
    input  wire logic       reqSerial,           // wanted mode
    output logic            sink_hotplug_in,     // sink hot-plug
    output logic      [3:0] source_power_sense,  // source power
    output logic      [1:0] port_select_pins,    // port pins
    output logic            control_mode_select, // mode pin
    output logic            linkClockValid       // clock detect
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------
    // sources and sink controller
    // ------------------------------------------------
    initial begin
        sink_hotplug_in = 1'h0;
        source_power_sense = 4'h0;
        port_select_pins = 2'h0;
        control_mode_select = 1'h0;
        linkClockValid = 1'h0;
        forever begin
            @(posedge mclk);
            source_power_sense <= reqPower;
            control_mode_select <= reqSerial;
            linkClockValid <= reqClock;
            if (reqPort != port_select_pins) begin
                sink_hotplug_in <= 1'h0;
                repeat (4) @(posedge mclk);
                port_select_pins <= reqPort;
                repeat (4) @(posedge mclk);
            end
            sink_hotplug_in <= reqSink;
        end
    end
endmodule

//--- power_mode_hotplug_control_bench.sv
module power_mode_hotplug_control_bench
    import power_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       mclk = 1'h0;
    logic       rst_n = 1'h0;
    logic       low_power_pin_n = 1'h1;
    logic       regWrite = 1'h0;
    logic       regRead = 1'h0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWriteData = 8'h00;
    logic [1:0] reqPort = 2'h0;
    logic       reqSink = 1'h1;
    logic [3:0] reqPower = 4'h0;
    logic       reqClock = 1'h0;
    logic       reqSerial = 1'h0;
    logic       sink_hotplug_in, control_mode_select, linkClockValid, irq;
    logic       source_power_indicator, linkOutputEnable;
    logic [1:0] port_select_pins;
    logic [3:0] source_power_sense, port_hotplug_out, receiverEnable;
    logic [3:0] clockTermEnable, dataTermEnable, ddcRepeaterEnable;
    logic [7:0] regReadData, rdata;
    int         errors = 0;
    int         num_checks = 0;

    always #2.5 mclk = ~mclk;

    far_side_model i_far_side_model (
        .mclk, .reqPort, .reqSink, .reqPower, .reqClock, .reqSerial,
        .sink_hotplug_in, .source_power_sense, .port_select_pins,
        .control_mode_select, .linkClockValid
    );

    power_mode_hotplug_control i_power_mode_hotplug_control (
        .mclk, .rst_n, .low_power_pin_n, .sink_hotplug_in, .source_power_sense,
        .port_select_pins, .control_mode_select, .linkClockValid, .regAddr,
        .regWriteData, .regWrite, .regRead, .regReadData, .port_hotplug_out,
        .source_power_indicator, .receiverEnable, .clockTermEnable, .dataTermEnable,
        .ddcRepeaterEnable, .linkOutputEnable, .irq
    );

    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic conclude();
        if (errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle();
        repeat (16) @(posedge mclk);
        #1;
    endtask

    task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWrite <= 1'h1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge mclk);
        regWrite <= 1'h0;
    endtask

    task automatic readReg(input logic [7:0] a);
        @(posedge mclk);
        regRead <= 1'h1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'h0;
        #1;
        rdata = regReadData;
    endtask

    function automatic logic [3:0] hpExp(input logic [3:0] pw, input logic [1:0] p);
        hpExp = pw;
        hpExp[p] = reqSink;
    endfunction

    task automatic expNormal(input logic [1:0] p);
        logic [7:0] one;
        one = 8'h01 << p;
        check({4'h0, receiverEnable}, one);
        check({4'h0, ddcRepeaterEnable}, one);
        check({4'h0, clockTermEnable}, one);
        check({4'h0, dataTermEnable}, reqClock ? one : 8'h00);
        check({7'h0, linkOutputEnable}, {7'h0, reqClock});
        check({4'h0, port_hotplug_out}, {4'h0, hpExp(reqPower, p)});
        check({7'h0, source_power_indicator}, {7'h0, |reqPower});
    endtask

    task automatic expOff();
        check({receiverEnable, dataTermEnable}, 8'h00);
        check({clockTermEnable, ddcRepeaterEnable}, 8'h00);
        check({7'h0, linkOutputEnable}, 8'h00);
        check({4'h0, port_hotplug_out}, {4'h0, reqPower});
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_pin_strap();
        reqPower = 4'ha;
        for (int p = 0; p < 4; p++) begin
            reqPort = p[1:0];
            reqClock = 1'h0;
            settle();
            expNormal(p[1:0]);
            reqClock = 1'h1;
            settle();
            expNormal(p[1:0]);
        end
    endtask

    task automatic t_low_power_pin();
        reqPower = 4'h5;
        @(posedge mclk);
        low_power_pin_n <= 1'h0;
        settle();
        expOff();
        @(posedge mclk);
        low_power_pin_n <= 1'h1;
        settle();
        expNormal(reqPort);
    endtask

    task automatic t_standby();
        writeReg(CONTROL_ADDR, 8'h40);
        settle();
        check({4'h0, receiverEnable}, 8'h08);
        reqSerial = 1'h1;
        writeReg(CONTROL_ADDR, 8'h42);
        settle();
        check({receiverEnable, dataTermEnable}, 8'h00);
        check({clockTermEnable, 3'h0, linkOutputEnable}, 8'h00);
        check({4'h0, ddcRepeaterEnable}, 8'h04);
        check({4'h0, port_hotplug_out}, {4'h0, hpExp(reqPower, 2'h2)});
        readReg(CONTROL_ADDR);
        check(rdata, 8'h42);
        @(posedge mclk);
        low_power_pin_n <= 1'h0;
        settle();
        expOff();
        @(posedge mclk);
        low_power_pin_n <= 1'h1;
        settle();
    endtask

    task automatic t_reg_low_power();
        writeReg(CONTROL_ADDR, 8'hc2);
        settle();
        expOff();
        writeReg(CONTROL_ADDR, 8'h82);
        settle();
        expOff();
        writeReg(CONTROL_ADDR, 8'h02);
        settle();
        expNormal(2'h2);
    endtask

    task automatic t_status();
        reqPower = 4'h9;
        settle();
        readReg(STATUS_ADDR);
        check(rdata, 8'h69);
        readReg(8'h7f);
        check(rdata, 8'h00);
        reqSerial = 1'h0;
        settle();
        readReg(STATUS_ADDR);
        check(rdata, 8'h00);
        reqSerial = 1'h1;
        settle();
    endtask

    task automatic t_irq();
        writeReg(INT_STAT_ADDR, 8'h0f);
        writeReg(INT_MASK_ADDR, 8'h01);
        settle();
        check({7'h0, irq}, 8'h00);
        readReg(INT_MASK_ADDR);
        check(rdata, 8'h01);
        reqPower = 4'h3;
        settle();
        check({7'h0, irq}, 8'h01);
        readReg(INT_STAT_ADDR);
        check(rdata, 8'h01);
        writeReg(INT_STAT_ADDR, 8'h01);
        settle();
        check({7'h0, irq}, 8'h00);
        writeReg(INT_MASK_ADDR, 8'h00);
        reqPower = 4'h0;
        settle();
        check({7'h0, irq}, 8'h00);
        check({7'h0, source_power_indicator}, 8'h00);
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'h1;
        settle();
        readReg(CONTROL_ADDR);
        check(rdata, CONTROL_RESET);
        readReg(INT_MASK_ADDR);
        check(rdata, {4'h0, INT_MASK_RESET});
        t_pin_strap();
        t_low_power_pin();
        t_standby();
        t_reg_low_power();
        t_status();
        t_irq();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        conclude();
    end
endmodule
